// ===== logic/lane_tx_level_sel.sv
// per-lane choice of drive level and de-emphasis source
`timescale 1ns/100ps
`default_nettype none
`include "serdes_tx_regs.svh"
module lane_tx_level_sel
  import serdes_tx_pkg::*;
(
  // lane settings
  input  wire logic [15:0] ctl_a,
  input  wire logic [15:0] ctl_b,
  // operating mode
  input  wire logic        gen2,
  input  wire logic        low_swing,
  input  wire logic        margin_on,
  // chosen settings
  output tx_src_t          src,
  output logic      [4:0]  drive,
  output logic      [1:0]  coarse,
  output logic      [2:0]  fine,
  output logic      [1:0]  eq,
  output logic      [1:0]  boost
);
  // boost is kept in every mode, margining included
  assign boost = ctl_a[11:10];

  // source priority: margin, then low swing, then lane registers
  always_comb begin
    src    = SRC_LANE;
    drive  = gen2 ? ctl_a[9:5] : ctl_a[4:0];
    coarse = ctl_b[1:0];
    fine   = ctl_b[4:2];
    eq     = ctl_b[6:5];
    if (margin_on) begin
      src   = SRC_MARGIN;
      drive = 5'h00;
    end else if (low_swing) begin
      src   = SRC_LOW;
      drive = {1'b0, gen2 ? ctl_b[15:12] : ctl_b[11:8]};
    end
    if (low_swing) begin
      coarse = `DEEMPH_OFF_COARSE;
      fine   = `DEEMPH_OFF_FINE;
      eq     = 2'h0;
    end
  end
endmodule
`default_nettype wire

// ===== logic/serdes_tx_ctl.sv
// transmit level, margining and lane power control of one transceiver quad
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "serdes_tx_regs.svh"
module serdes_tx_ctl
  import serdes_tx_pkg::*;
#(
  parameter int NL = 4
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // link state from the physical layer
  input  wire logic [3:0]        ltssm_state,
  input  wire logic              gen2,
  input  wire logic              link_up,
  input  wire logic              detect_done,
  input  wire logic [NL-1:0]     detect_lanes,
  input  wire logic [NL-1:0]     active_lanes,
  // port ownership
  input  wire logic [NL-1:0]     lane_port_disabled,
  input  wire logic              port_wide,
  // towards the LTSSM
  output logic                   retrain_pulse,
  output logic                   sel_deemph,
  output logic                   comp_deemph,
  output logic                   deemph_by_ltssm,
  output logic                   deemph_off,
  output logic                   deemph_status_valid,
  // transmit settings
  output logic                   margin_on,
  output logic      [9:0]        margin_mv,
  output logic      [NL*2-1:0]   tx_source,
  output logic      [NL*5-1:0]   tx_drive,
  output logic      [NL*2-1:0]   tx_coarse,
  output logic      [NL*3-1:0]   tx_fine,
  output logic      [NL*2-1:0]   tx_eq,
  output logic      [NL*2-1:0]   tx_boost,
  // receiver equalization
  output logic      [NL*4-1:0]   rx_eq_zero,
  output logic      [NL*4-1:0]   rx_eq_boost,
  // power
  output logic                   quad_power_on,
  output logic      [NL*2-1:0]   lane_power
);
  if (NL != 4) begin : g_bad_nl
    $error("serdes_tx_ctl serves one quad of four lanes only");
  end

  typedef struct packed {
    logic                  retrain;
    logic [2:0]            tm_req;
    logic                  selectable_deemph;
    logic                  cde;
    logic                  low_swing_enable;
    logic                  pwrdn;
    logic [NL-1:0][15:0]   lane_a;
    logic [NL-1:0][15:0]   lane_b;
    logic [NL-1:0][7:0]    rx_eq;
    logic [2:0]            tm_applied;
    logic                  comp_lsw;
    logic [NL-1:0]         used;
    logic [3:0]            lt_q;
    logic [31:0]           rdata;
    logic                  err;
    logic                  m_on;
    logic [9:0]            mv;
    logic [NL-1:0][1:0]    src;
    logic [NL-1:0][4:0]    drv;
    logic [NL-1:0][1:0]    crs;
    logic [NL-1:0][2:0]    fin;
    logic [NL-1:0][1:0]    eqs;
    logic [NL-1:0][1:0]    bst;
    logic                  q_on;
    logic [NL-1:0][1:0]    pwr;
  } state_t;

  state_t q;
  state_t next_q;

  // margin code to millivolts, reserved codes clamp to lowest level
  function automatic logic [9:0] margin_level(input logic [2:0] code, input logic lsw);
    logic [2:0] c;
    c = (code > `TM_LAST) ? `TM_LAST : code;
    case (c)
      3'h0:    margin_level = lsw ? `MV_LS0 : `MV_FS0;
      3'h1:    margin_level = lsw ? `MV_LS1 : `MV_FS1;
      3'h2:    margin_level = lsw ? `MV_LS2 : `MV_FS2;
      3'h3:    margin_level = lsw ? `MV_LS3 : `MV_FS3;
      default: margin_level = lsw ? `MV_LS4 : `MV_FS4;
    endcase
  endfunction

  // address decode: 0 none, 1 valid
  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a[11:4] <= `REGION_RX_EQ);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // per-lane level selection
  logic                in_comp;
  logic                comp_entry;
  logic                m_on_now;
  tx_src_t             l_src [NL];
  logic [NL-1:0][4:0]  l_drv;
  logic [NL-1:0][1:0]  l_crs;
  logic [NL-1:0][2:0]  l_fin;
  logic [NL-1:0][1:0]  l_eq;
  logic [NL-1:0][1:0]  l_bst;

  assign in_comp    = (ltssm_state == LT_POLL_COMP);
  assign comp_entry = in_comp && (q.lt_q != LT_POLL_COMP);
  assign m_on_now   = (q.tm_applied != `TM_NORMAL) || in_comp;

  for (genvar i = 0; i < NL; i++) begin : g_lane
    lane_tx_level_sel u_sel (
      .ctl_a     (q.lane_a[i]),
      .ctl_b     (q.lane_b[i]),
      .gen2      (gen2),
      .low_swing (q.low_swing_enable),
      .margin_on (m_on_now),
      .src       (l_src[i]),
      .drive     (l_drv[i]),
      .coarse    (l_crs[i]),
      .fine      (l_fin[i]),
      .eq        (l_eq[i]),
      .boost     (l_bst[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // next state: bus, margin, power
  always_comb begin
    logic       setup;
    logic       wr;
    logic [1:0] ln;
    logic [7:0] rg;
    logic [31:0] rd;
    next_q = q;
    setup  = psel && !penable;
    wr     = psel && penable && pwrite && q.err == 1'b0;
    ln     = paddr[3:2];
    rg     = paddr[11:4];
    rd     = 32'h0000_0000;
    next_q.retrain = 1'b0;
    next_q.lt_q    = ltssm_state;
    // register writes take effect at the access edge
    if (wr) begin
      if (paddr == `OFS_LINK_CONTROL) begin
        next_q.retrain = pwdata[`LC_RETRAIN_BIT];
      end else if (paddr == `OFS_LINK_CONTROL_2) begin
        next_q.tm_req = pwdata[`LC2_TM_LSB +: 3];
        next_q.selectable_deemph    = pwdata[`LC2_SDE_BIT];
        next_q.cde    = pwdata[`LC2_CDE_BIT];
      end else if (paddr == `OFS_QUAD_CONTROL) begin
        next_q.low_swing_enable   = pwdata[`QC_LSE_BIT];
        next_q.pwrdn = pwdata[`QC_PWRDN_BIT];
      end else if (rg == `REGION_LANE_A) begin
        next_q.lane_a[ln] = pwdata[15:0];
      end else if (rg == `REGION_LANE_B) begin
        next_q.lane_b[ln] = pwdata[15:0];
      end else if (rg == `REGION_RX_EQ) begin
        next_q.rx_eq[ln] = pwdata[7:0];
      end
    end
    // read data and error captured in the setup cycle
    if (paddr == `OFS_LINK_CONTROL_2) begin
      rd[`LC2_TM_LSB +: 3] = q.tm_req;
      rd[`LC2_SDE_BIT]     = q.selectable_deemph;
      rd[`LC2_CDE_BIT]     = q.cde;
    end else if (paddr == `OFS_QUAD_CONTROL) begin
      rd[`QC_LSE_BIT]   = q.low_swing_enable;
      rd[`QC_PWRDN_BIT] = q.pwrdn;
    end else if (paddr == `OFS_STATUS) begin
      rd = {12'h000, q.pwr, q.used, 2'h0, q.q_on, q.m_on, q.tm_applied, !q.low_swing_enable};
    end else if (rg == `REGION_LANE_A) begin
      rd[15:0] = q.lane_a[ln];
    end else if (rg == `REGION_LANE_B) begin
      rd[15:0] = q.lane_b[ln];
    end else if (rg == `REGION_RX_EQ) begin
      rd[7:0] = q.rx_eq[ln];
    end
    if (setup) begin
      next_q.rdata = rd;
      next_q.err   = !addr_ok(paddr);
    end
    // margin applied only in permitted states
    if (ltssm_state == LT_RCVRLOCK || comp_entry) begin
      next_q.tm_applied = q.tm_req;
    end
    if (comp_entry) begin
      next_q.comp_lsw = q.low_swing_enable;
    end
    next_q.m_on = m_on_now;
    next_q.mv   = m_on_now ? margin_level(q.tm_applied, in_comp ? q.comp_lsw : q.low_swing_enable)
                           : 10'h000;
    // used lanes latched at each detect
    if (detect_done && ltssm_state == LT_DETECT) begin
      next_q.used = detect_lanes;
    end
    for (int i = 0; i < NL; i++) begin
      next_q.src[i] = l_src[i];
      next_q.drv[i] = l_drv[i];
      next_q.crs[i] = l_crs[i];
      next_q.fin[i] = l_fin[i];
      next_q.eqs[i] = l_eq[i];
      next_q.bst[i] = l_bst[i];
    end
    // quad power
    next_q.q_on = !q.pwrdn && !(port_wide && lane_port_disabled[0]) &&
                  !(&lane_port_disabled);
    // lane power
    for (int i = 0; i < NL; i++) begin
      if (!next_q.q_on || lane_port_disabled[i]) begin
        next_q.pwr[i] = PWR_DEEP;
      end else if (!q.used[i]) begin
        next_q.pwr[i] = PWR_DOWN;
      end else if (link_up && !active_lanes[i]) begin
        next_q.pwr[i] = PWR_P1;
      end else begin
        next_q.pwr[i] = PWR_P0;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign pready              = 1'b1;
  assign prdata              = q.rdata;
  assign pslverr             = q.err && psel && penable;
  assign retrain_pulse       = q.retrain;
  assign sel_deemph          = q.selectable_deemph && !q.low_swing_enable;
  assign comp_deemph         = q.cde && !q.low_swing_enable;
  assign deemph_by_ltssm     = q.m_on && (q.lt_q == LT_POLL_COMP) && !q.low_swing_enable;
  assign deemph_off          = q.low_swing_enable;
  assign deemph_status_valid = !q.low_swing_enable;
  assign margin_on           = q.m_on;
  assign margin_mv           = q.mv;
  assign tx_source           = q.src;
  assign tx_drive            = q.drv;
  assign tx_coarse           = q.crs;
  assign tx_fine             = q.fin;
  assign tx_eq               = q.eqs;
  assign tx_boost            = q.bst;
  assign quad_power_on       = q.q_on;
  assign lane_power          = q.pwr;
  for (genvar i = 0; i < NL; i++) begin : g_rx
    assign rx_eq_zero[i*4 +: 4]  = q.rx_eq[i][3:0];
    assign rx_eq_boost[i*4 +: 4] = q.rx_eq[i][7:4];
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_margin_src;
    @(posedge pclk) disable iff (!presetn)
      q.m_on |-> (q.src[0] == SRC_MARGIN && q.drv[0] == 5'h00);
  endproperty
  a_margin_src: assert property (p_margin_src) else $error("margin not in control");

  property p_margin_defer;
    @(posedge pclk) disable iff (!presetn)
      (ltssm_state != LT_RCVRLOCK && !comp_entry) |=> $stable(q.tm_applied);
  endproperty
  a_margin_defer: assert property (p_margin_defer) else $error("margin applied early");

  sequence s_comp_enter;
    (ltssm_state != LT_POLL_COMP) ##1 (ltssm_state == LT_POLL_COMP);
  endsequence
  property p_comp_table;
    @(posedge pclk) disable iff (!presetn)
      s_comp_enter |=> (q.comp_lsw == $past(q.low_swing_enable)) && q.m_on;
  endproperty
  a_comp_table: assert property (p_comp_table) else $error("compliance swing mode wrong");

  property p_low_swing_deemph;
    @(posedge pclk) disable iff (!presetn)
      q.low_swing_enable |-> (!deemph_status_valid && !sel_deemph && !comp_deemph && deemph_off)
                ##1 (q.crs[0] == `DEEMPH_OFF_COARSE && q.fin[0] == `DEEMPH_OFF_FINE);
  endproperty
  a_low_swing_deemph: assert property (p_low_swing_deemph) else $error("de-emphasis not off");

  property p_boost_kept;
    @(posedge pclk) disable iff (!presetn)
      ##1 (q.bst[1] == $past(q.lane_a[1][11:10]));
  endproperty
  a_boost_kept: assert property (p_boost_kept) else $error("boost not applied");

  property p_quad_pwrdn;
    @(posedge pclk) disable iff (!presetn)
      q.pwrdn |=> (!q.q_on && q.pwr[0] == PWR_DEEP && q.pwr[3] == PWR_DEEP);
  endproperty
  a_quad_pwrdn: assert property (p_quad_pwrdn) else $error("quad stayed powered");

  property p_wide_disabled;
    @(posedge pclk) disable iff (!presetn)
      (port_wide && lane_port_disabled[0]) |=> !q.q_on;
  endproperty
  a_wide_disabled: assert property (p_wide_disabled) else $error("quad not deep");

  property p_detect_used;
    @(posedge pclk) disable iff (!presetn)
      (detect_done && ltssm_state == LT_DETECT) |=> q.used == $past(detect_lanes);
  endproperty
  a_detect_used: assert property (p_detect_used) else $error("used lanes not latched");

  property p_width_p1;
    @(posedge pclk) disable iff (!presetn)
      (q.q_on && !q.pwrdn && !lane_port_disabled[1] && !(&lane_port_disabled)
       && !(port_wide && lane_port_disabled[0]) && q.used[1] && link_up
       && !active_lanes[1]) |=> q.pwr[1] == PWR_P1;
  endproperty
  a_width_p1: assert property (p_width_p1) else $error("inactive lane not in P1");
endmodule
`default_nettype wire

// ===== logic/serdes_tx_pkg.sv
// types shared by the transmit level and lane power control
package serdes_tx_pkg;
  typedef enum logic [3:0] {
    LT_DETECT    = 4'h0,
    LT_POLLING   = 4'h1,
    LT_POLL_COMP = 4'h2,
    LT_CONFIG    = 4'h3,
    LT_L0        = 4'h4,
    LT_RCVRLOCK  = 4'h5,
    LT_OTHER     = 4'hf
  } ltssm_t;
  typedef enum logic [1:0] {
    PWR_P0   = 2'h0,
    PWR_P1   = 2'h1,
    PWR_DOWN = 2'h2,
    PWR_DEEP = 2'h3
  } lane_pwr_t;
  typedef enum logic [1:0] {
    SRC_LANE   = 2'h0,
    SRC_MARGIN = 2'h1,
    SRC_LOW    = 2'h2
  } tx_src_t;
endpackage

// ===== logic/serdes_tx_regs.svh
// register offsets, field positions, reset values and level tables of the transmit control
`ifndef SERDES_TX_REGS_SVH
`define SERDES_TX_REGS_SVH
`define OFS_LINK_CONTROL   12'h000
`define OFS_LINK_CONTROL_2 12'h004
`define OFS_QUAD_CONTROL   12'h008
`define OFS_STATUS         12'h00c
`define REGION_LANE_A      8'h01
`define REGION_LANE_B      8'h02
`define REGION_RX_EQ       8'h03
`define LC_RETRAIN_BIT     5
`define LC2_SDE_BIT        6
`define LC2_TM_LSB         7
`define LC2_CDE_BIT        12
`define QC_LSE_BIT         0
`define QC_PWRDN_BIT       1
`define LANE_REG_RESET     16'h0000
`define RX_EQ_RESET        8'h00
`define DEEMPH_OFF_COARSE  2'h3
`define DEEMPH_OFF_FINE    3'h7
`define TM_NORMAL          3'h0
`define TM_LAST            3'h4
`define MV_FS0 10'h384
`define MV_FS1 10'h2bc
`define MV_FS2 10'h1f4
`define MV_FS3 10'h12c
`define MV_FS4 10'h0c8
`define MV_LS0 10'h1f4
`define MV_LS1 10'h190
`define MV_LS2 10'h12c
`define MV_LS3 10'h0c8
`define MV_LS4 10'h064
`endif

// ===== tb/link_partner_model.sv
// link partner model: steps the training state seen by the control block
`timescale 1ns/100ps
`default_nettype none
module link_partner_model
  import serdes_tx_pkg::*;
(
  // clock
  input  wire logic       pclk,
  // link state towards the block
  output logic      [3:0] ltssm_state,
  output logic            gen2,
  output logic            link_up,
  output logic            detect_done,
  output logic      [3:0] detect_lanes,
  output logic      [3:0] active_lanes
);
  // idle link at time zero
  initial begin
    ltssm_state = LT_DETECT;
    gen2 = 1'b0;
    detect_done = 1'b0;
    detect_lanes = 4'h0;
    active_lanes = 4'h0;
  end
  // link counts as up in L0 and while passing through recovery
  always_ff @(posedge pclk) begin
    link_up <= (ltssm_state == LT_L0) || (ltssm_state == LT_RCVRLOCK);
  end
  // detect, then train up to L0 on the lanes seen
  task automatic train(input logic [3:0] lanes);
    @(posedge pclk);
    ltssm_state <= LT_DETECT;
    detect_lanes <= lanes;
    detect_done <= 1'b1;
    @(posedge pclk);
    detect_done <= 1'b0;
    detect_lanes <= ~lanes; // result no longer valid
    ltssm_state <= LT_POLLING;
    @(posedge pclk);
    ltssm_state <= LT_CONFIG;
    @(posedge pclk);
    ltssm_state <= LT_L0;
    active_lanes <= lanes;
  endtask
  // one pass through recovery, where a new margin may land
  task automatic recover();
    @(posedge pclk);
    ltssm_state <= LT_RCVRLOCK;
    @(posedge pclk);
    ltssm_state <= LT_L0;
  endtask
  // hold a given training state
  task automatic set_state(input logic [3:0] st);
    @(posedge pclk);
    ltssm_state <= st;
  endtask
  // width change while the link stays up
  task automatic shrink(input logic [3:0] lanes);
    @(posedge pclk);
    active_lanes <= lanes;
  endtask
  // speed change
  task automatic set_gen2(input logic g);
    @(posedge pclk);
    gen2 <= g;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_serdes_tx_ctl.sv
// testbench of the transmit level and lane power control
`timescale 1ns/100ps
`default_nettype none
`include "serdes_tx_regs.svh"
module tb_serdes_tx_ctl
  import serdes_tx_pkg::*;
;
  typedef struct packed {
    logic       low_swing_enable;
    logic [2:0] tm;
    logic [9:0] mv;
    logic       on;
  } row_t;
  ////////////////////////////////////////////////////////////////////////////////
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, retrain_pulse, sel_deemph, comp_deemph;
  logic deemph_by_ltssm, deemph_off, deemph_status_valid, margin_on, quad_power_on;
  logic [3:0] ltssm_state, detect_lanes, active_lanes;
  logic [3:0] lane_port_disabled = 4'h0;
  logic port_wide = 1'b0;
  logic gen2, link_up, detect_done;
  logic [9:0] margin_mv;
  logic [7:0] tx_source, tx_coarse, tx_eq, tx_boost, lane_power;
  logic [19:0] tx_drive;
  logic [11:0] tx_fine;
  logic [15:0] rx_eq_zero, rx_eq_boost;
  logic [31:0] rd;
  logic err;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  localparam row_t rows [12] = '{
    '{1'b0, 3'h0, 10'h000, 1'b0}, '{1'b0, 3'h1, `MV_FS1, 1'b1}, '{1'b0, 3'h2, `MV_FS2, 1'b1},
    '{1'b0, 3'h3, `MV_FS3, 1'b1}, '{1'b0, 3'h4, `MV_FS4, 1'b1}, '{1'b0, 3'h7, `MV_FS4, 1'b1},
    '{1'b1, 3'h0, 10'h000, 1'b0}, '{1'b1, 3'h1, `MV_LS1, 1'b1}, '{1'b1, 3'h2, `MV_LS2, 1'b1},
    '{1'b1, 3'h3, `MV_LS3, 1'b1}, '{1'b1, 3'h4, `MV_LS4, 1'b1}, '{1'b1, 3'h7, `MV_LS4, 1'b1}};
  localparam logic [11:0] reg_addr [8] = '{12'h000, 12'h004, 12'h008, 12'h010, 12'h020,
                                           12'h030, 12'h040, 12'h002};
  ////////////////////////////////////////////////////////////////////////////////
  // clock
  always #5 pclk = ~pclk;
  serdes_tx_ctl #(.NL(4)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ltssm_state(ltssm_state), .gen2(gen2), .link_up(link_up), .detect_done(detect_done),
    .detect_lanes(detect_lanes), .active_lanes(active_lanes),
    .lane_port_disabled(lane_port_disabled), .port_wide(port_wide),
    .retrain_pulse(retrain_pulse), .sel_deemph(sel_deemph), .comp_deemph(comp_deemph),
    .deemph_by_ltssm(deemph_by_ltssm), .deemph_off(deemph_off),
    .deemph_status_valid(deemph_status_valid), .margin_on(margin_on), .margin_mv(margin_mv),
    .tx_source(tx_source), .tx_drive(tx_drive), .tx_coarse(tx_coarse), .tx_fine(tx_fine),
    .tx_eq(tx_eq), .tx_boost(tx_boost), .rx_eq_zero(rx_eq_zero), .rx_eq_boost(rx_eq_boost),
    .quad_power_on(quad_power_on), .lane_power(lane_power));
  link_partner_model i_lp (
    .pclk(pclk), .ltssm_state(ltssm_state), .gen2(gen2), .link_up(link_up),
    .detect_done(detect_done), .detect_lanes(detect_lanes), .active_lanes(active_lanes));
  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic final_report();
    $display("checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // compare seen against expected
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one apb transfer, held until pready at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // let registered outputs and power state land
  task automatic settle();
    repeat (3) @(posedge pclk);
    #1;
  endtask
  // hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (7) @(posedge pclk);
    #1;
    chk("rst margin_on", margin_on, 0);
    chk("rst quad_on", quad_power_on, 0);
    chk("rst lane_power", lane_power, 0);
    chk("rst status_valid", deemph_status_valid, 1);
    chk("rst pready", pready, 1);
    chk("rst prdata", prdata, 0);
    chk("rst pslverr", pslverr, 0);
    @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, reg_addr[i], 32'h0);
      chk("reg rdata", rd, 0);
      chk("reg err", err, i > 5);
    end
    i_lp.train(4'b0011);
    settle();
    chk("used quad_on", quad_power_on, 1);
    chk("used lane_power", lane_power, 8'ha0);
    for (int i = 0; i < 12; i++) begin
      apb(1'b1, `OFS_QUAD_CONTROL, {31'h0, rows[i].low_swing_enable});
      apb(1'b1, `OFS_LINK_CONTROL_2, {22'h0, rows[i].tm, 7'h0});
      apb(1'b1, `OFS_LINK_CONTROL, 32'h20);
      i_lp.recover();
      settle();
      chk("row margin_mv", margin_mv, rows[i].mv);
      chk("row margin_on", margin_on, rows[i].on);
      $display("row %0d done", i);
    end
    apb(1'b1, `OFS_QUAD_CONTROL, 32'h0);
    apb(1'b1, 12'h010, 32'h80a);
    apb(1'b1, 12'h020, 32'h5c29);
    apb(1'b1, `OFS_LINK_CONTROL_2, 32'h1040);
    i_lp.recover();
    settle();
    chk("lane drive", tx_drive[4:0], 5'h0a);
    chk("lane de-emph", {tx_coarse[1:0], tx_fine[2:0], tx_eq[1:0]}, 7'b01_010_01);
    chk("lane src", tx_source[1:0], SRC_LANE);
    chk("sel_deemph", sel_deemph, 1);
    chk("comp_deemph", comp_deemph, 1);
    apb(1'b1, `OFS_LINK_CONTROL_2, 32'h140);
    i_lp.recover();
    settle();
    chk("margin src", tx_source[1:0], SRC_MARGIN);
    chk("margin boost", tx_boost[1:0], 2'h2);
    apb(1'b1, `OFS_LINK_CONTROL_2, 32'h1c0);
    settle();
    chk("deferred mv", margin_mv, `MV_FS2);
    i_lp.recover();
    settle();
    chk("applied mv", margin_mv, `MV_FS3);
    apb(1'b1, `OFS_LINK_CONTROL_2, 32'h1040);
    i_lp.recover();
    apb(1'b1, `OFS_QUAD_CONTROL, 32'h1);
    settle();
    chk("low de-emph", {deemph_off, deemph_status_valid, sel_deemph, comp_deemph}, 4'b1000);
    chk("low lane", {tx_coarse[1:0], tx_fine[2:0], tx_eq[1:0]}, 7'b11_111_00);
    chk("low src", tx_source[1:0], SRC_LOW);
    chk("low gen1", tx_drive[4:0], 5'h0c);
    i_lp.set_gen2(1'b1);
    settle();
    chk("low gen2", tx_drive[4:0], 5'h05);
    i_lp.set_gen2(1'b0);
    i_lp.set_state(LT_POLL_COMP);
    settle();
    chk("comp low mv", margin_mv, `MV_LS0);
    chk("comp low ltssm", deemph_by_ltssm, 0);
    i_lp.set_state(LT_L0);
    apb(1'b1, `OFS_QUAD_CONTROL, 32'h0);
    i_lp.set_state(LT_POLL_COMP);
    settle();
    chk("comp full mv", margin_mv, `MV_FS0);
    chk("comp full", {margin_on, deemph_by_ltssm}, 2'b11);
    i_lp.set_state(LT_L0);
    apb(1'b1, 12'h034, 32'h5a);
    apb(1'b0, 12'h034, 32'h0);
    chk("rx eq read", rd, 32'h5a);
    chk("rx eq", {rx_eq_boost[7:4], rx_eq_zero[7:4]}, 8'h5a);
    apb(1'b1, `OFS_LINK_CONTROL, 32'h20);
    #1;
    chk("retrain on", retrain_pulse, 1);
    @(posedge pclk);
    #1;
    chk("retrain off", retrain_pulse, 0);
    $display("levels done");
    i_lp.shrink(4'b0001);
    settle();
    chk("shrink power", lane_power, 8'ha4);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("status", rd, 32'h000a_4321);
    i_lp.train(4'b1111);
    settle();
    chk("retrain power", lane_power, 8'h00);
    @(posedge pclk);
    lane_port_disabled <= 4'b0001;
    settle();
    chk("x1 off", lane_power, 8'h03);
    @(posedge pclk);
    lane_port_disabled <= 4'b1111;
    settle();
    chk("all off", {quad_power_on, lane_power}, 9'h0ff);
    @(posedge pclk);
    port_wide <= 1'b1;
    lane_port_disabled <= 4'b0001;
    settle();
    chk("x4 off", {quad_power_on, lane_power}, 9'h0ff);
    @(posedge pclk);
    lane_port_disabled <= 4'b0000;
    port_wide <= 1'b0;
    apb(1'b1, `OFS_QUAD_CONTROL, 32'h2);
    settle();
    chk("quad down", {quad_power_on, lane_power}, 9'h0ff);
    $display("power done");
    final_report();
  end
endmodule
`default_nettype wire
